// ---- hw/hpp_pkg.sv ----
`default_nettype none
package hpp_pkg;
  localparam int NPORT = 4;
  localparam int AW = 4;
  localparam int DW = 32;
  // register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT = 4'h4;
  localparam logic [AW-1:0] ADDR_FILT = 4'h8;
  localparam logic [AW-1:0] ADDR_IDENT = 4'hC;
  // control fields
  localparam int CTRL_REQ_LSB = 0;
  localparam int CTRL_GANG_BIT = 4;
  // status fields
  localparam int STAT_OC_LSB = 0;
  localparam int STAT_PWR_LSB = 4;
  localparam int STAT_LS_LSB = 8;
  localparam int STAT_GANG_BIT = 12;
  localparam int STAT_BUS_BIT = 13;
  localparam int STAT_DIRECT_BIT = 14;
  localparam int STAT_MEM_BIT = 15;
  // identifier fields
  localparam int IDENT_PID_LSB = 0;
  localparam int IDENT_VID_LSB = 16;
  // filter length, in core clock cycles
  localparam logic [7:0] FILT_RST = 8'h10;
  localparam logic [7:0] FILT_MIN = 8'h01;
  // clock plan
  localparam int XTAL_MHZ = 6;
  localparam int FAST_MHZ = 48;
  localparam int BIT_MHZ = 12;
  localparam logic [3:0] PLL_MULT = 4'(FAST_MHZ / XTAL_MHZ);
  localparam logic [1:0] BIT_DIV_LAST = 2'(FAST_MHZ / BIT_MHZ - 1);
  // arbitrary identifier values
  localparam logic [15:0] DEF_PID = 16'h1234;
  localparam logic [15:0] DEF_VID = 16'hABCD;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b11
  } hpp_state_t;
endpackage : hpp_pkg
`default_nettype wire

// ---- hw/hpp_top.sv ----
// Notes on behaviour
// - ganged strap high, memory strap high: all power enables together
// - ganged: any overcurrent powers off every port
// - ganged low: per-port enable and overcurrent
// - overcurrent inputs are noise filtered
// - clock strap low: core clocked from PLL
// - clock strap high: direct clock, PLL, oscillator down
// - crystal mode: 6 to 48 MHz, 12 MHz sync
// - memory strap high: default id, clock off, grouping from gang strap
// - memory strap low: shared pins are serial memory
// - power strap high bus-powered, low self-powered
// - each port detects speed, sets slew rate
// - power enable outputs are active low push-pull
// - overcurrent inputs are active low
`default_nettype none
module hpp_top
  import hpp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rd_data,
  input wire logic clock_source_strap,
  input wire logic memory_enable_strap_n,
  input wire logic power_source_strap,
  input wire logic [NPORT-1:0] port_overcurrent_n,
  output logic [NPORT-1:0] port_power_enable_n,
  input wire logic [NPORT-1:0] port_fs_pullup,
  input wire logic [NPORT-1:0] port_ls_pullup,
  output logic [NPORT-1:0] port_slew_slow,
  input wire logic fast_clk_tick,
  output logic direct_clock_select,
  output logic analog_pll_power_down,
  output logic oscillator_power_down,
  output logic [3:0] analog_pll_multiplier,
  output logic usb_bit_strobe,
  output logic power_bus_mode,
  output logic serial_memory_clock_o,
  output logic serial_memory_clock_oe,
  input wire logic serial_memory_data_i,
  output logic serial_memory_data_o,
  output logic serial_memory_data_oe,
  input wire logic mem_clk_drive,
  input wire logic mem_data_drive,
  input wire logic mem_data_drive_en,
  output logic mem_data_sample,
  input wire logic custom_id_valid,
  input wire logic [15:0] custom_vendor_identifier,
  input wire logic [15:0] custom_product_identifier,
  output logic [15:0] vendor_identifier,
  output logic [15:0] product_identifier
);

  ////////////////////////////////////////////////////////////////
  hpp_state_t state_reg;
  logic clk_strap_reg, mem_strap_n_reg, bus_strap_reg, gang_strap_reg;
  logic gang_sw_reg;
  logic ganged, running;
  logic [7:0] filt_len_reg;
  logic [NPORT-1:0] req_reg;
  logic [NPORT-1:0] oc_lat_reg;
  logic [NPORT-1:0] oc_act, oc_rise, kill;
  logic [NPORT-1:0] oc_act_d_reg;
  logic [7:0] cnt_reg [NPORT];
  logic [1:0] div_reg;
  logic wr_ctrl, wr_stat, wr_filt, wr_ganged;
  logic [DW-1:0] rd_mux;

  assign running = (state_reg == ST_RUN);
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_stat = reg_wr && (reg_addr == ADDR_STAT);
  assign wr_filt = reg_wr && (reg_addr == ADDR_FILT);

  ////////////////////////////////////////////////////////////////
  // straps are caught in the second cycle after reset release, then frozen;
  // the board must not move them while running
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
    end else begin
      unique case (state_reg)
        ST_RESET: state_reg <= ST_CAPTURE;
        ST_CAPTURE: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clk_strap_reg <= 1'b0;
      mem_strap_n_reg <= 1'b1;
      bus_strap_reg <= 1'b0;
      gang_strap_reg <= 1'b0;
    end else if (state_reg == ST_CAPTURE) begin
      clk_strap_reg <= clock_source_strap;
      mem_strap_n_reg <= memory_enable_strap_n;
      bus_strap_reg <= power_source_strap;
      gang_strap_reg <= serial_memory_data_i;
    end
  end

  // with the memory in use the data pin is busy, so software picks mode
  assign ganged = mem_strap_n_reg ? gang_strap_reg : gang_sw_reg;
  // a write that flips grouping must already fill its requests the new way
  assign wr_ganged = mem_strap_n_reg ? gang_strap_reg : reg_wr_data[CTRL_GANG_BIT];

  ////////////////////////////////////////////////////////////////
  // overcurrent filter, one counter per port
  generate
    for (genvar i = 0; i < NPORT; i++) begin : g_port
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          cnt_reg[i] <= 8'h00;
        end else if (port_overcurrent_n[i]) begin
          cnt_reg[i] <= 8'h00;
        end else if (cnt_reg[i] != filt_len_reg) begin
          cnt_reg[i] <= cnt_reg[i] + 8'h01;
        end
      end
      assign oc_act[i] = (cnt_reg[i] == filt_len_reg);
      assign oc_rise[i] = oc_act[i] && !oc_act_d_reg[i];
      assign kill[i] = ganged ? (|oc_rise) : oc_rise[i];

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          req_reg[i] <= 1'b0;
        end else if (kill[i]) begin
          req_reg[i] <= 1'b0;
        end else if (wr_ctrl && running) begin
          req_reg[i] <= wr_ganged ? reg_wr_data[CTRL_REQ_LSB]
                               : reg_wr_data[CTRL_REQ_LSB + i];
        end
      end

      // set wins over a write-one clear in the same cycle
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          oc_lat_reg[i] <= 1'b0;
        end else if (kill[i]) begin
          oc_lat_reg[i] <= 1'b1;
        end else if (wr_stat && reg_wr_data[STAT_OC_LSB + i]) begin
          oc_lat_reg[i] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          port_power_enable_n[i] <= 1'b1;
        end else begin
          port_power_enable_n[i] <= !(running && req_reg[i]);
        end
      end

      // a pull-up on the minus line marks a low-speed device
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          port_slew_slow[i] <= 1'b0;
        end else if (port_ls_pullup[i] && !port_fs_pullup[i]) begin
          port_slew_slow[i] <= 1'b1;
        end else if (port_fs_pullup[i] && !port_ls_pullup[i]) begin
          port_slew_slow[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oc_act_d_reg <= '0;
    end else begin
      oc_act_d_reg <= oc_act;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gang_sw_reg <= 1'b0;
    end else if (wr_ctrl) begin
      gang_sw_reg <= reg_wr_data[CTRL_GANG_BIT];
    end
  end

  // zero length would flag a fault on a quiet input
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      filt_len_reg <= FILT_RST;
    end else if (wr_filt) begin
      filt_len_reg <= (reg_wr_data[7:0] == 8'h00) ? FILT_MIN : reg_wr_data[7:0];
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      ADDR_CTRL: begin
        rd_mux[CTRL_REQ_LSB +: NPORT] = req_reg;
        rd_mux[CTRL_GANG_BIT] = gang_sw_reg;
      end
      ADDR_STAT: begin
        rd_mux[STAT_OC_LSB +: NPORT] = oc_lat_reg;
        rd_mux[STAT_PWR_LSB +: NPORT] = ~port_power_enable_n;
        rd_mux[STAT_LS_LSB +: NPORT] = port_slew_slow;
        rd_mux[STAT_GANG_BIT] = ganged;
        rd_mux[STAT_BUS_BIT] = bus_strap_reg;
        rd_mux[STAT_DIRECT_BIT] = clk_strap_reg;
        rd_mux[STAT_MEM_BIT] = !mem_strap_n_reg;
      end
      ADDR_FILT: rd_mux[7:0] = filt_len_reg;
      ADDR_IDENT: begin
        rd_mux[IDENT_PID_LSB +: 16] = product_identifier;
        rd_mux[IDENT_VID_LSB +: 16] = vendor_identifier;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rd_data <= '0;
    end else begin
      reg_rd_data <= reg_rd ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // clock source control
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      direct_clock_select <= 1'b0;
      analog_pll_power_down <= 1'b0;
      oscillator_power_down <= 1'b0;
      analog_pll_multiplier <= PLL_MULT;
    end else begin
      direct_clock_select <= clk_strap_reg;
      analog_pll_power_down <= clk_strap_reg;
      oscillator_power_down <= clk_strap_reg;
      analog_pll_multiplier <= PLL_MULT;
    end
  end

  // 48 MHz ticks divided down to the 12 MHz bit strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_reg <= 2'h0;
      usb_bit_strobe <= 1'b0;
    end else begin
      usb_bit_strobe <= running && fast_clk_tick && (div_reg == BIT_DIV_LAST);
      if (!running) begin
        div_reg <= 2'h0;
      end else if (fast_clk_tick) begin
        div_reg <= (div_reg == BIT_DIV_LAST) ? 2'h0 : div_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      power_bus_mode <= 1'b0;
    end else begin
      power_bus_mode <= bus_strap_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared serial memory pins; both stay undriven until straps are known
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      serial_memory_clock_o <= 1'b0;
      serial_memory_clock_oe <= 1'b0;
      serial_memory_data_o <= 1'b0;
      serial_memory_data_oe <= 1'b0;
      mem_data_sample <= 1'b0;
    end else begin
      serial_memory_clock_o <= mem_clk_drive && !mem_strap_n_reg;
      serial_memory_clock_oe <= running && !mem_strap_n_reg;
      serial_memory_data_o <= mem_data_drive;
      serial_memory_data_oe <= running && !mem_strap_n_reg && mem_data_drive_en;
      mem_data_sample <= serial_memory_data_i && !mem_strap_n_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      product_identifier <= DEF_PID;
      vendor_identifier <= DEF_VID;
    end else if (!mem_strap_n_reg && custom_id_valid) begin
      product_identifier <= custom_product_identifier;
      vendor_identifier <= custom_vendor_identifier;
    end else if (mem_strap_n_reg) begin
      product_identifier <= DEF_PID;
      vendor_identifier <= DEF_VID;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_ganged_same_level: assert property (
    running && $past(running) && ganged && $past(ganged)
      |-> port_power_enable_n == {NPORT{port_power_enable_n[0]}})
    else $error("ganged power enables differ");
  a_ganged_trip_all: assert property (
    running && ganged && (|oc_rise) |-> ##2 (&port_power_enable_n))
    else $error("ganged overcurrent left a port powered");
  a_port_trip_own: assert property (
    running && !ganged && oc_rise[2] |-> ##2 port_power_enable_n[2])
    else $error("port overcurrent did not remove its power");
  a_port_keep_other: assert property (
    running && !ganged && oc_rise[2] && !oc_rise[0] && !oc_rise[1] && !oc_rise[3]
      && req_reg[0] && !wr_ctrl |=> req_reg[0])
    else $error("per-port trip hit another port");
  a_spike_resets: assert property (
    port_overcurrent_n[2] |=> cnt_reg[2] == 8'h00)
    else $error("filter count survived a high input");
  a_filter_len: assert property (
    $rose(oc_lat_reg[2]) && !ganged |-> $past(cnt_reg[2]) == $past(filt_len_reg))
    else $error("overcurrent accepted before filter length");
  a_clock_source: assert property (
    running |=> direct_clock_select == clk_strap_reg
      && analog_pll_power_down == clk_strap_reg && oscillator_power_down == clk_strap_reg)
    else $error("clock source does not follow strap");
  a_bit_strobe: assert property (
    usb_bit_strobe |=> !usb_bit_strobe [*3])
    else $error("bit strobe faster than one in four ticks");
  a_mem_off: assert property (
    running && mem_strap_n_reg |=> !serial_memory_clock_oe && !serial_memory_data_oe
      && product_identifier == DEF_PID)
    else $error("memory pins active with memory disabled");
  a_mem_on: assert property (
    running && !mem_strap_n_reg |=> serial_memory_clock_oe)
    else $error("memory clock not driven in memory mode");
  a_bus_mode: assert property (
    running |=> power_bus_mode == bus_strap_reg)
    else $error("power mode does not follow strap");
  a_slew_low: assert property (
    port_ls_pullup[3] && !port_fs_pullup[3] |=> port_slew_slow[3])
    else $error("low-speed device without slow slew");
  a_off_reset: assert property (
    !running |=> (&port_power_enable_n))
    else $error("port powered before run");

  c_ganged_trip: cover property (running && ganged && (|oc_rise));
  c_port_trip: cover property (running && !ganged && oc_rise[2]);
  c_mem_mode: cover property (running && !mem_strap_n_reg && custom_id_valid);
  c_bit_strobe: cover property (usb_bit_strobe ##8 usb_bit_strobe);

endmodule : hpp_top
`default_nettype wire

// ---- verif/hpp_switch_model.sv ----
`default_nettype none
module hpp_switch_model
  import hpp_pkg::*;
(
  input wire logic [NPORT-1:0] port_power_enable_n,
  input wire logic [NPORT-1:0] fault,
  input wire logic ganged,
  output logic [NPORT-1:0] port_overcurrent_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NPORT-1:0] trip;
  ////////////////////////////////////////////////////////////////////////////
  // a switch that is off carries no current, so it cannot flag a fault
  assign trip = fault & ~port_power_enable_n;
  // open-drain flags with pull-up; ganged boards tie all flags together
  assign port_overcurrent_n = ganged ? {NPORT{~|trip}} : ~trip;
endmodule : hpp_switch_model
`default_nettype wire

// ---- verif/hub_port_power_config_test.sv ----
`default_nettype none
module hub_port_power_config_test
  import hpp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wr_data = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic clock_source_strap = 1'h0;
  logic memory_enable_strap_n = 1'h1;
  logic power_source_strap = 1'h0;
  logic gang_strap = 1'h0;
  logic [NPORT-1:0] fault = '0;
  logic [NPORT-1:0] port_fs_pullup = '0;
  logic [NPORT-1:0] port_ls_pullup = '0;
  logic fast_clk_tick = 1'h0;
  logic mem_clk_drive = 1'h1;
  logic mem_data_drive = 1'h1;
  logic mem_data_drive_en = 1'h1;
  logic custom_id_valid = 1'h1;
  logic [15:0] custom_vendor_identifier = '0;
  logic [15:0] custom_product_identifier = '0;
  logic [DW-1:0] reg_rd_data;
  logic [NPORT-1:0] port_overcurrent_n, port_power_enable_n, port_slew_slow;
  logic direct_clock_select, analog_pll_power_down, oscillator_power_down;
  logic [3:0] analog_pll_multiplier;
  logic usb_bit_strobe, power_bus_mode, mem_data_sample;
  logic serial_memory_clock_o, serial_memory_clock_oe, serial_memory_data_i;
  logic serial_memory_data_o, serial_memory_data_oe;
  logic [15:0] vendor_identifier, product_identifier;
  logic [31:0] seed = 32'h4373351B;
  logic [31:0] strobe_cnt = '0;
  logic [31:0] d, base;
  logic [NPORT-1:0] sexp = '0;
  int fails = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  // shared data pin: driver wins, else strap level (pulldown in memory mode)
  assign serial_memory_data_i = serial_memory_data_oe ? serial_memory_data_o : gang_strap;
  hpp_top dut (.core_clk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
    .reg_rd_data, .clock_source_strap, .memory_enable_strap_n, .power_source_strap,
    .port_overcurrent_n, .port_power_enable_n, .port_fs_pullup, .port_ls_pullup,
    .port_slew_slow, .fast_clk_tick, .direct_clock_select, .analog_pll_power_down,
    .oscillator_power_down, .analog_pll_multiplier, .usb_bit_strobe, .power_bus_mode,
    .serial_memory_clock_o, .serial_memory_clock_oe, .serial_memory_data_i,
    .serial_memory_data_o, .serial_memory_data_oe, .mem_clk_drive, .mem_data_drive,
    .mem_data_drive_en, .mem_data_sample, .custom_id_valid, .custom_vendor_identifier,
    .custom_product_identifier, .vendor_identifier, .product_identifier);
  hpp_switch_model sw (.port_power_enable_n, .fault, .ganged(gang_strap),
    .port_overcurrent_n);
  always #2 core_clk = ~core_clk;
  // counts at the edge, so it sees the strobe value settled before that edge
  always @(posedge core_clk) strobe_cnt <= strobe_cnt + 32'(usb_bit_strobe);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // attach with one pullup decides speed; none or both keeps the old slew
  function automatic logic [3:0] slew_exp(input logic [3:0] p, fs, ls);
    return (ls & ~fs) | (p & ~(ls ^ fs));
  endfunction : slew_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the read edge
  task automatic rd(input logic [AW-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rd_data;
    @(posedge core_clk);
  endtask : rd
  task automatic restart(input logic cs, ps, mn, gs);
    @(posedge core_clk);
    sys_rst <= 1'h1;
    clock_source_strap <= cs;
    power_source_strap <= ps;
    memory_enable_strap_n <= mn;
    gang_strap <= gs;
    cyc(3);
    sys_rst <= 1'h0;
    cyc(4);
    #1;
  endtask : restart
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
  initial begin
    restart(1'h0, 1'h1, 1'h1, 1'h0);
    chk({direct_clock_select, analog_pll_power_down, oscillator_power_down}, 0);
    chk(analog_pll_multiplier, 4'h8);
    chk(power_bus_mode, 1);
    chk({vendor_identifier, product_identifier}, {DEF_VID, DEF_PID});
    chk({serial_memory_clock_oe, serial_memory_data_oe, mem_data_sample}, 0);
    @(posedge core_clk);
    rd(ADDR_IDENT);
    chk(d, {DEF_VID, DEF_PID});
    rd(ADDR_FILT);
    chk(d, 32'h10);
    rd(4'h2);
    chk(d, 0);
    wr(ADDR_CTRL, 32'hF);
    cyc(2);
    #1 chk(port_power_enable_n, 4'h0);
    @(posedge core_clk);
    wr(ADDR_FILT, 32'h4);
    // a spike one cycle shorter than the filter must leave power alone
    fault <= 4'h2;
    cyc(3);
    fault <= 4'h0;
    cyc(3);
    #1 chk(port_power_enable_n, 4'h0);
    @(posedge core_clk);
    fault <= 4'h4;
    cyc(5);
    #1 chk(port_power_enable_n, 4'h0);
    @(posedge core_clk);
    #1 chk(port_power_enable_n, 4'h4);
    @(posedge core_clk);
    fault <= 4'h0;
    rd(ADDR_STAT);
    chk(d[7:0], 8'hB4);
    wr(ADDR_STAT, 32'h4);
    rd(ADDR_STAT);
    chk(d[7:0], 8'hB0);
    wr(ADDR_FILT, 32'h0);
    rd(ADDR_FILT);
    chk(d, 32'h1);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr_next(seed);
      port_fs_pullup <= seed[3:0];
      port_ls_pullup <= seed[7:4];
      sexp = slew_exp(sexp, seed[3:0], seed[7:4]);
      cyc(3);
      #1 chk(port_slew_slow, sexp);
      @(posedge core_clk);
    end
    base = strobe_cnt;
    for (int i = 0; i < 130; i++) begin
      fast_clk_tick <= (i < 128) && !i[0];
      @(posedge core_clk);
    end
    cyc(1);
    #1 chk(strobe_cnt - base, 16);
    restart(1'h1, 1'h0, 1'h1, 1'h1);
    chk({direct_clock_select, analog_pll_power_down, oscillator_power_down}, 7);
    chk(power_bus_mode, 0);
    @(posedge core_clk);
    wr(ADDR_CTRL, 32'h1);
    cyc(2);
    #1 chk(port_power_enable_n, 4'h0);
    @(posedge core_clk);
    fault <= 4'h8;
    cyc(18);
    #1 chk(port_power_enable_n, 4'hF);
    @(posedge core_clk);
    fault <= 4'h0;
    rd(ADDR_STAT);
    chk(d[15:0], {4'h5, slew_exp(4'h0, port_fs_pullup, port_ls_pullup), 8'h0F});
    seed = lfsr_next(seed);
    custom_vendor_identifier <= seed[31:16];
    custom_product_identifier <= seed[15:0];
    restart(1'h0, 1'h0, 1'h0, 1'h0);
    chk({vendor_identifier, product_identifier}, seed);
    chk({serial_memory_clock_oe, serial_memory_clock_o}, 2'h3);
    chk({serial_memory_data_oe, serial_memory_data_o}, 2'h3);
    chk(mem_data_sample, 1);
    @(posedge core_clk);
    wr(ADDR_CTRL, 32'h11);
    cyc(2);
    #1 chk(port_power_enable_n, 4'h0);
    @(posedge core_clk);
    // engine lets go of the data pin: it falls to its pulldown level
    mem_data_drive_en <= 1'h0;
    cyc(3);
    #1 chk({serial_memory_data_oe, mem_data_sample}, 0);
    report_and_stop();
  end
endmodule : hub_port_power_config_test
`default_nettype wire
